// >>> design/status_irq_map.svh
// Purpose: Register offsets, reset values and widths for status/irq block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Definitions only
`ifndef STATUS_IRQ_MAP_SVH
`define STATUS_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SUPPLY_OK_STATUS_ADDR 8'h02
`define SUPPLY_IRQ_MASK_ADDR  8'h03
`define EVENT_IRQ_MASK_ADDR   8'h04
`define SUPPLY_IRQ_FLAGS_ADDR 8'h05
`define EVENT_IRQ_FLAGS_ADDR  8'h06

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SUPPLY_IRQ_MASK_RESET 8'hFF
`define EVENT_IRQ_MASK_RESET  8'hFF
`define FLAGS_RESET           8'h00
`define READ_IDLE_VALUE       8'h00

// ----------------------------------------------------------------
// Event register field positions
// ----------------------------------------------------------------
`define EV_CONV_DONE_BIT      7
`define EV_HIGH_IMP_BIT       6
`define EV_PIN_TWO_BIT        5
`define EV_PIN_ONE_BIT        4
`define EV_THERMAL_BIT        3
`define EV_CHARGER_BIT        2
`define EV_ABOVE_BIT          1
`define EV_BELOW_BIT          0

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define REG_W                 8
`define CHARGER_W             4
`define SYNC_W                23

`endif

// >>> design/status_irq_pkg.sv
// Purpose: Types shared by the status and interrupt block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Offsets and values live in status_irq_map.svh
package status_irq_pkg;

    typedef enum logic [0:0] {
        IRQ_IDLE   = 1'b0,
        IRQ_ACTIVE = 1'b1
    } irq_state_type;

endpackage

// >>> design/input_sync.sv
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk
// Notes:   Output follows only when second and third stages agree
`timescale 1ns/1ps

module input_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    // Per bit: a glitch seen by one stage only is not passed on
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= (stage3 & agree) | (sync_out & ~agree);
        end
    end

endmodule

// >>> design/status_and_irq_mask_regs.sv
// Purpose: Supply status register, interrupt masks, flags and irq_n
// Assumes: Register port driven by the serial-bus slave on ref_clk
// Notes:   All status inputs arrive from other domains and are synced
//
// Functional notes
// - Irq logic runs only once normal_mode is reported; supply status reads at any time.
// - Read-only supply status at 02, bit set means fault.
// - Supply status reads the live synced supply state, not a constant.
// - Supply irq mask at 03, read/write, 1 masks each supply.
// - Event irq mask at 04, read/write, 1 masks each event source.
// - ADC limit violations are internal only, used as interrupt sources.
// - Analog input high impedance is internal only, an interrupt source.
// - Thermal fault is internal status, a maskable interrupt source.
// - Unmasked toggle sets its flags and drives irq_n low on the same clock edge.
// - While irq_n is low, flags change only by clearing writes and new changes are ignored.
// - New interrupts only after irq_n has returned high.
`timescale 1ns/1ps
`include "status_irq_map.svh"

module status_and_irq_mask_regs
    import status_irq_pkg::*;
#(
    parameter int CHARGER_W = `CHARGER_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 normal_mode,
    input  wire logic [7:0]           supply_fault,
    input  wire logic                 conv_done,
    input  wire logic                 high_impedance,
    input  wire logic                 pin_two,
    input  wire logic                 pin_one,
    input  wire logic                 thermal_fault,
    input  wire logic [CHARGER_W-1:0] charger_state_bits,
    input  wire logic                 above_limit,
    input  wire logic                 below_limit,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    output logic                      irq_n
);

    localparam int SW = 16 + CHARGER_W;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [SW-1:0] raw_in;
    logic [SW-1:0] synced;
    logic [SW-1:0] prev;
    logic          mode_synced;
    logic          primed;

    assign raw_in = {supply_fault, conv_done, high_impedance, pin_two,
                     pin_one, thermal_fault, above_limit, below_limit,
                     normal_mode, charger_state_bits};

    input_sync #(
        .WIDTH(SW)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .async_in(raw_in),
        .sync_out(synced)
    );

    // ----------------------------------------------------------------
    // Status and toggle detection
    // ----------------------------------------------------------------
    logic [7:0]           supply_ok_status;
    logic [7:0]           supply_toggle;
    logic [CHARGER_W-1:0] charger_now;
    logic [CHARGER_W-1:0] charger_prev;
    logic [7:0]           event_now;
    logic [7:0]           event_prev;
    logic [7:0]           event_toggle;

    assign mode_synced      = synced[CHARGER_W];
    assign charger_now      = synced[CHARGER_W-1:0];
    assign charger_prev     = prev[CHARGER_W-1:0];
    assign supply_ok_status = synced[SW-1:SW-8];
    assign event_now        = {synced[SW-9:SW-13], 1'b0, synced[SW-14],
                               synced[SW-15]};
    assign event_prev       = {prev[SW-9:SW-13], 1'b0, prev[SW-14],
                               prev[SW-15]};

    assign supply_toggle = supply_ok_status ^ prev[SW-1:SW-8];
    assign event_toggle  = (event_now ^ event_prev)
        | ({7'h00, |(charger_now ^ charger_prev)} << `EV_CHARGER_BIT);

    // ----------------------------------------------------------------
    // Registers and interrupt controller
    // ----------------------------------------------------------------
    logic [7:0]    supply_irq_mask;
    logic [7:0]    event_irq_mask;
    logic [7:0]    supply_irq_flags;
    logic [7:0]    event_irq_flags;
    irq_state_type state;

    logic       live;
    logic [7:0] supply_hit;
    logic [7:0] event_hit;
    logic       any_hit;
    logic       wr_smask;
    logic       wr_emask;
    logic       wr_sflag;
    logic       wr_eflag;
    logic [7:0] cleared_sflags;
    logic [7:0] cleared_eflags;
    logic [7:0] next_rdata;

    // Comparing before priming would flag every high input as a toggle
    assign live       = mode_synced && primed;
    assign supply_hit = supply_toggle & ~supply_irq_mask;
    assign event_hit  = event_toggle & ~event_irq_mask;
    assign any_hit    = live && ((|supply_hit) || (|event_hit));

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------
    // Strobes come from logic on this clock, so they bypass the sync
    assign wr_smask = reg_wr && (reg_addr == `SUPPLY_IRQ_MASK_ADDR);
    assign wr_emask = reg_wr && (reg_addr == `EVENT_IRQ_MASK_ADDR);
    assign wr_sflag = reg_wr && (reg_addr == `SUPPLY_IRQ_FLAGS_ADDR);
    assign wr_eflag = reg_wr && (reg_addr == `EVENT_IRQ_FLAGS_ADDR);

    // Writing 0 clears a flag; writing 1 leaves it as it is
    assign cleared_sflags = wr_sflag ? (supply_irq_flags & reg_wdata)
                                     : supply_irq_flags;
    assign cleared_eflags = wr_eflag ? (event_irq_flags & reg_wdata)
                                     : event_irq_flags;

    // ----------------------------------------------------------------
    // Read data select
    // ----------------------------------------------------------------
    // Unmapped addresses read zero so a stray read is harmless
    assign next_rdata =
        (reg_addr == `SUPPLY_OK_STATUS_ADDR) ? supply_ok_status :
        (reg_addr == `SUPPLY_IRQ_MASK_ADDR)  ? supply_irq_mask  :
        (reg_addr == `EVENT_IRQ_MASK_ADDR)   ? event_irq_mask   :
        (reg_addr == `SUPPLY_IRQ_FLAGS_ADDR) ? supply_irq_flags :
        (reg_addr == `EVENT_IRQ_FLAGS_ADDR)  ? event_irq_flags  :
                                               `READ_IDLE_VALUE;

    // ----------------------------------------------------------------
    // Status history
    // ----------------------------------------------------------------
    // History follows every cycle, so a toggle seen while irq_n is low
    // is consumed rather than deferred
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev   <= '0;
            primed <= 1'b0;
        end else begin
            prev   <= synced;
            primed <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Mask registers and read data
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            supply_irq_mask <= `SUPPLY_IRQ_MASK_RESET;
            event_irq_mask  <= `EVENT_IRQ_MASK_RESET;
            reg_rdata       <= `READ_IDLE_VALUE;
        end else begin
            if (wr_smask) begin
                supply_irq_mask <= reg_wdata;
            end
            if (wr_emask) begin
                event_irq_mask <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt state machine
    // ----------------------------------------------------------------
    // Flags are set only when idle and cleared only when active, so a
    // set and a clear can never meet in one cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state            <= IRQ_IDLE;
            supply_irq_flags <= `FLAGS_RESET;
            event_irq_flags  <= `FLAGS_RESET;
            irq_n            <= 1'b1;
        end else begin
            unique case (state)
                IRQ_IDLE: begin
                    if (any_hit) begin
                        supply_irq_flags <= supply_hit;
                        event_irq_flags  <= event_hit;
                        irq_n            <= 1'b0;
                        state            <= IRQ_ACTIVE;
                    end
                end
                IRQ_ACTIVE: begin
                    // Toggles are dropped here, not queued
                    supply_irq_flags <= cleared_sflags;
                    event_irq_flags  <= cleared_eflags;
                    // A partial clear keeps irq_n low
                    if (cleared_sflags == 8'h00 &&
                        cleared_eflags == 8'h00) begin
                        irq_n <= 1'b1;
                        state <= IRQ_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// >>> tb/status_irq_chk.sv
// Purpose: Port assertions for the status and irq block
// Assumes: Bound to the top module, sees its ports only
// Notes:   Flag writes are the only way irq_n may rise
`timescale 1ns/1ps
module status_irq_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       normal_mode,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire flag_wr = reg_wr && (reg_addr == 8'h05 || reg_addr == 8'h06);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    rd_hold_a: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr > 8'h06 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    supply_mask_a: assert property (
        reg_wr && reg_addr == 8'h03 ##1 reg_rd && reg_addr == 8'h03
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("supply mask readback wrong");
    event_mask_a: assert property (
        reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("event mask readback wrong");
    irq_mode_a: assert property (
        $fell(irq_n) |-> $past(normal_mode))
        else $error("irq outside normal mode");
    irq_hold_a: assert property (
        !irq_n && !flag_wr |=> !irq_n)
        else $error("irq released without flag write");
    irq_release_a: assert property (
        $rose(irq_n) |-> $past(flag_wr))
        else $error("irq rose without flag write");
    irq_gap_a: assert property (
        irq_n && reg_rd && (reg_addr == 8'h05 || reg_addr == 8'h06)
        |=> reg_rdata == 8'h00)
        else $error("flag stands while irq high");
endmodule
bind status_and_irq_mask_regs status_irq_chk i_status_irq_chk (
    .ref_clk, .rst, .normal_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_n);

// >>> tb/host_model.sv
// Purpose: Host side of the register port
// Assumes: Calls start just after a clock edge
// Notes:   Write data inverted once released so stale data never matches
`timescale 1ns/1ps
module host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    end
    // Clearing a flag is a write of 0
    task automatic wr(input logic [7:0] a, v, input bit back,
                      output logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~v;
        reg_rd = back;
        if (back) begin
            @(posedge ref_clk) #1;
            reg_rd = 1'b0;
        end
        d = reg_rdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// >>> tb/testbench.sv
// Purpose: Register and interrupt sequences for the status block
// Assumes: Default charger width of four
// Notes:   All event sources toggle together; masks pick the winner
`timescale 1ns/1ps
module testbench;
    logic       ref_clk = 0, rst = 1, normal_mode = 0;
    logic [7:0] supply_fault = 8'h00, ev = 8'h00, d;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, irq_n;
    int         n_fail = 0, n_compared = 0, i;
    status_and_irq_mask_regs i_status_and_irq_mask_regs (
        .ref_clk, .rst, .normal_mode, .supply_fault,
        .conv_done(ev[7]), .high_impedance(ev[6]), .pin_two(ev[5]),
        .pin_one(ev[4]), .thermal_fault(ev[3]),
        .charger_state_bits({4{ev[2]}}), .above_limit(ev[1]),
        .below_limit(ev[0]), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq_n);
    host_model i_host_model (.ref_clk, .reg_rdata, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", what, e, s);
        end
    endtask
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 20 && irq_n !== lvl; k++) idle(1);
        check("irq_n", {7'h0, irq_n}, {7'h0, lvl});
        if (irq_n !== lvl) final_report();
    endtask
    initial begin
        idle(6);
        rst = 0;
        i_host_model.rd(8'h03, d);
        check("supply mask", d, 8'hFF);
        i_host_model.rd(8'h04, d);
        check("event mask", d, 8'hFF);
        i_host_model.rd(8'h07, d);
        check("unmapped", d, 8'h00);
        i_host_model.wr(8'h04, 8'h00, 1, d);
        check("ev mask", d, 8'h00);
        ev = 8'hFF;
        idle(3);
        ev = 8'h00;
        idle(12);
        check("irq before mode", {7'h0, irq_n}, 8'h01);
        normal_mode = 1;
        supply_fault = 8'hA5;
        idle(10);
        i_host_model.wr(8'h02, 8'h00, 0, d);
        i_host_model.rd(8'h02, d);
        check("status", d, 8'hA5);
        for (i = 0; i < 8; i++) begin
            i_host_model.wr(8'h04, ~(8'h01 << i), 0, d);
            ev = ~ev;
            wait_irq(0);
            i_host_model.rd(8'h06, d);
            check("ev flags", d, 8'h01 << i);
            i_host_model.wr(8'h06, 8'h00, 0, d);
            wait_irq(1);
        end
        i_host_model.wr(8'h04, 8'hFF, 0, d);
        i_host_model.wr(8'h03, 8'h7E, 1, d);
        check("sup mask", d, 8'h7E);
        supply_fault = supply_fault ^ 8'hFF;
        wait_irq(0);
        i_host_model.rd(8'h05, d);
        check("sup flags", d, 8'h81);
        supply_fault = supply_fault ^ 8'h01;
        idle(12);
        i_host_model.rd(8'h05, d);
        check("frozen", d, 8'h81);
        i_host_model.rd(8'h02, d);
        check("status live", d, 8'h5B);
        i_host_model.wr(8'h05, 8'h00, 0, d);
        wait_irq(1);
        idle(12);
        check("no reissue", {7'h0, irq_n}, 8'h01);
        i_host_model.rd(8'h05, d);
        check("cleared", d, 8'h00);
        final_report();
    end
endmodule
